/* scpc_modem.sv */
// modem side of one channel: receive data, clear-to-send, carrier
// assumes a free-running bit clock that the unit samples on its rise
`timescale 1ns/1ps
module scpc_modem (
	input  wire logic bclk,
	input  wire logic txd,
	output logic      rxd,
	output logic      cts_b,
	output logic      dcd_b
);
	// idle mark, ready to take data, carrier present
	initial begin
		rxd = 1'b1;
		cts_b = 1'b0;
		dcd_b = 1'b0;
	end
	// frame to the unit: start, data lsb first, stop, m clocks a bit
	task automatic send(input logic [7:0] d, input int m);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10 * m; i++) begin
			@(negedge bclk);
			rxd <= f[i / m];
		end
	endtask
	// frame from the unit, each bit taken at its middle
	task automatic get(input int m, output logic [7:0] d, output logic ok);
		int n;
		n = 0;
		d = 8'h00;
		@(negedge bclk);
		while (txd !== 1'b0 && n < 4000) begin
			@(negedge bclk);
			n++;
		end
		repeat (m / 2) @(negedge bclk);
		for (int i = 0; i < 8; i++) begin
			repeat (m) @(negedge bclk);
			d[i] = txd;
		end
		repeat (m) @(negedge bclk);
		ok = n < 4000 && txd === 1'b1;
	endtask
endmodule

/* scpc_pkg.sv */
// shared constants, types and helpers for the two-channel serial pin controller
// assumes 8-bit register port and bit clocks arriving on their own pins
package scpc_pkg;

	localparam int SCPC_AW     = 8;
	localparam int SCPC_DW     = 8;
	localparam int SCPC_NCH    = 2;
	localparam int SCPC_CH_BIT = 4;

	// register offsets within one channel window
	localparam logic [3:0] SCPC_OFF_CTRL = 4'h0;
	localparam logic [3:0] SCPC_OFF_TXD  = 4'h1;
	localparam logic [3:0] SCPC_OFF_RXD  = 4'h2;
	localparam logic [3:0] SCPC_OFF_STAT = 4'h3;
	localparam logic [3:0] SCPC_OFF_SYNC = 4'h4;
	localparam logic [2:0] SCPC_HI_ZERO  = 3'h0;

	// clock multiplier codes
	localparam logic [1:0] SCPC_MUL_X1  = 2'h0;
	localparam logic [1:0] SCPC_MUL_X16 = 2'h1;
	localparam logic [1:0] SCPC_MUL_X32 = 2'h2;
	localparam logic [1:0] SCPC_MUL_X64 = 2'h3;

	// bit period minus one and half period minus one, in bit clock cycles
	localparam logic [5:0] SCPC_DIV_X1  = 6'h00;
	localparam logic [5:0] SCPC_DIV_X16 = 6'h0f;
	localparam logic [5:0] SCPC_DIV_X32 = 6'h1f;
	localparam logic [5:0] SCPC_DIV_X64 = 6'h3f;
	localparam logic [5:0] SCPC_HALF_X16 = 6'h07;
	localparam logic [5:0] SCPC_HALF_X32 = 6'h0f;
	localparam logic [5:0] SCPC_HALF_X64 = 6'h1f;

	// data bits plus stop bit left after the start bit
	localparam logic [3:0] SCPC_TX_LEFT = 4'h9;
	localparam logic [7:0] SCPC_RD_NONE = 8'h00;

	typedef struct packed {
		logic       sync_ext;  // 1: sync pin is an input
		logic       dtr_on;    // terminal ready asserted
		logic       wr_ready;  // 1: ready use, 0: wait use
		logic       wr_en;     // wait/ready function enabled
		logic [1:0] mult;      // clock multiplier code
	} scpc_ctrl_t;

	typedef struct packed {
		logic sync_hit;
		logic sync_in;
		logic dcd;
		logic cts;
		logic tx_busy;
		logic rx_full;
	} scpc_stat_t;

	localparam scpc_ctrl_t SCPC_CTRL_RST = 6'h00;

	function automatic logic [5:0] scpc_div_m1(input logic [1:0] m);
		case (m)
			SCPC_MUL_X16: scpc_div_m1 = SCPC_DIV_X16;
			SCPC_MUL_X32: scpc_div_m1 = SCPC_DIV_X32;
			SCPC_MUL_X64: scpc_div_m1 = SCPC_DIV_X64;
			default:      scpc_div_m1 = SCPC_DIV_X1;
		endcase
	endfunction

	function automatic logic [5:0] scpc_half_m1(input logic [1:0] m);
		case (m)
			SCPC_MUL_X16: scpc_half_m1 = SCPC_HALF_X16;
			SCPC_MUL_X32: scpc_half_m1 = SCPC_HALF_X32;
			SCPC_MUL_X64: scpc_half_m1 = SCPC_HALF_X64;
			default:      scpc_half_m1 = SCPC_DIV_X1;
		endcase
	endfunction

endpackage

/* scpc_rx.sv */
// receiver of one channel, clocked by that channel's receive bit clock
// assumes the multiplier code is held steady while frames arrive
`timescale 1ns/1ps
module scpc_rx #(
	parameter int DW = scpc_pkg::SCPC_DW
) (
	input  wire logic          rx_clk,
	input  wire logic          rst_b,
	input  wire logic          serial_in,
	input  wire logic          carrier_b,
	input  wire logic [1:0]    mult_raw,
	output logic      [DW-1:0] rx_word_ff,
	output logic               done_tgl_ff
);
	import scpc_pkg::*;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} scpc_rx_st_t;

	scpc_rx_st_t      state_ff, nxt_state;
	logic [3:0]       meta_ff, sync_ff;
	logic [5:0]       cnt_ff, nxt_cnt;
	logic [2:0]       bit_ff, nxt_bit;
	logic [DW-1:0]    shift_ff, nxt_shift, nxt_word;
	logic             nxt_tgl;

	// synchronised pin levels and config
	wire logic       rxd        = sync_ff[0];
	wire logic       carrier_ok = ~sync_ff[1];
	wire logic [1:0] mult       = sync_ff[3:2];
	wire logic [5:0] div_m1     = scpc_div_m1(mult);
	wire logic [5:0] half_m1    = scpc_half_m1(mult);
	wire logic       cnt_zero   = (cnt_ff == SCPC_DIV_X1);

	// two-flop synchronisers for pins and config
	always_ff @(posedge rx_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= '1;
			sync_ff <= '1;
		end else begin
			meta_ff <= {mult_raw, carrier_b, serial_in};
			sync_ff <= meta_ff;
		end
	end

	// frame sequencer: start edge, centre sampling, stop check
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_bit   = bit_ff;
		nxt_shift = shift_ff;
		nxt_word  = rx_word_ff;
		nxt_tgl   = done_tgl_ff;
		case (state_ff)
			RX_IDLE: begin
				if (!rxd && carrier_ok) begin
					if (mult == SCPC_MUL_X1) begin
						nxt_state = RX_DATA;
						nxt_cnt   = SCPC_DIV_X1;
					end else begin
						nxt_state = RX_START;
						nxt_cnt   = half_m1;
					end
					nxt_bit = '0;
				end
			end
			RX_START: begin
				if (!carrier_ok) begin
					nxt_state = RX_IDLE;
				end else if (cnt_zero) begin
					nxt_state = rxd ? RX_IDLE : RX_DATA; // glitch rejection
					nxt_cnt   = div_m1;
				end else begin
					nxt_cnt = cnt_ff - 6'h01;
				end
			end
			RX_DATA: begin
				if (!carrier_ok) begin
					nxt_state = RX_IDLE;
				end else if (cnt_zero) begin
					nxt_shift = {rxd, shift_ff[DW-1:1]};
					nxt_bit   = bit_ff + 3'h1;
					nxt_cnt   = div_m1;
					if (bit_ff == 3'(DW - 1)) begin
						nxt_state = RX_STOP;
					end
				end else begin
					nxt_cnt = cnt_ff - 6'h01;
				end
			end
			RX_STOP: begin
				if (cnt_zero) begin
					nxt_state = RX_IDLE;
					if (rxd) begin
						nxt_word = shift_ff;
						nxt_tgl  = ~done_tgl_ff;
					end
				end else begin
					nxt_cnt = cnt_ff - 6'h01;
				end
			end
			default: nxt_state = RX_IDLE;
		endcase
	end

	// sequencer registers
	always_ff @(posedge rx_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff    <= RX_IDLE;
			cnt_ff      <= '0;
			bit_ff      <= '0;
			shift_ff    <= '0;
			rx_word_ff  <= '0;
			done_tgl_ff <= '0;
		end else begin
			state_ff    <= nxt_state;
			cnt_ff      <= nxt_cnt;
			bit_ff      <= nxt_bit;
			shift_ff    <= nxt_shift;
			rx_word_ff  <= nxt_word;
			done_tgl_ff <= nxt_tgl;
		end
	end

	rx_carrier_gate_a: assert property (@(posedge rx_clk) disable iff (!rst_b)
		(state_ff == RX_IDLE && nxt_state != RX_IDLE) |-> carrier_ok)
		else $error("receiver started without carrier");
	rx_bit_spacing_a: assert property (@(posedge rx_clk) disable iff (!rst_b)
		(state_ff == RX_DATA && cnt_zero && carrier_ok) |=> (cnt_ff == $past(div_m1)))
		else $error("receive bit period wrong");
	rx_centre_wait_a: assert property (@(posedge rx_clk) disable iff (!rst_b)
		(state_ff == RX_IDLE && nxt_state == RX_START) |=> (cnt_ff == $past(half_m1)))
		else $error("start bit centre count wrong");
endmodule

/* scpc_top.sv */
// two-channel serial unit pin control: registers, flow control, modem lines
// assumes bit clocks are unrelated to sys_clk; one-cycle register strobes
//
// Behaviour
// - in async mode the receiver takes a receive clock of 1, 16, 32 or 64 times the bit rate.
// - in async mode the transmitter takes a transmit clock of 1, 16, 32 or 64 times the rate.
// - in wait use the wait/ready pin goes to 1 to hold the processor while not ready.
// - in ready use the wait/ready pin goes to 0 when the channel can take a transfer.
// - with external sync the sync pin is an input and sync is taken from outside.
// - with internal sync the sync pin is an output reporting detected sync.
// - the send request output is low while the channel sends data and high otherwise; the code also holds it low while a byte waits for clear-to-send.
// - a low carrier detect permits reception on that channel.
// - terminal ready is asserted while the channel is ready and deasserted when not; the code drives it from the dtr_on control bit instead.
// - each channel shifts data in on its serial input and out on its serial output.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module scpc_top (
	input  wire logic                         sys_clk,
	input  wire logic                         rst_b,
	input  wire logic [scpc_pkg::SCPC_AW-1:0] reg_addr,
	input  wire logic [scpc_pkg::SCPC_DW-1:0] reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [scpc_pkg::SCPC_DW-1:0] reg_rdata,
	input  wire logic                         rx_bit_clock_a,
	input  wire logic                         rx_bit_clock_b,
	input  wire logic                         tx_bit_clock_a,
	input  wire logic                         tx_bit_clock_b,
	input  wire logic                         serial_in_a,
	input  wire logic                         serial_in_b,
	output logic                              serial_out_a,
	output logic                              serial_out_b,
	output logic                              wait_ready_out_a,
	output logic                              wait_ready_out_b,
	input  wire logic                         sync_pin_a_in,
	output logic                              sync_pin_a_out,
	output logic                              sync_pin_a_oe,
	input  wire logic                         sync_pin_b_in,
	output logic                              sync_pin_b_out,
	output logic                              sync_pin_b_oe,
	output logic                              send_request_or_clear_a_b,
	output logic                              send_request_or_clear_b_b,
	input  wire logic                         clear_to_send_a_b,
	input  wire logic                         clear_to_send_b_b,
	input  wire logic                         carrier_detect_a_b,
	input  wire logic                         carrier_detect_b_b,
	output logic                              terminal_ready_a_b,
	output logic                              terminal_ready_b_b
);
	import scpc_pkg::*;

	localparam int NCH = SCPC_NCH;

	// per-channel pin bundles
	wire logic [NCH-1:0] rxc     = {rx_bit_clock_b, rx_bit_clock_a};
	wire logic [NCH-1:0] txc     = {tx_bit_clock_b, tx_bit_clock_a};
	wire logic [NCH-1:0] sin     = {serial_in_b, serial_in_a};
	wire logic [NCH-1:0] cts_raw = {clear_to_send_b_b, clear_to_send_a_b};
	wire logic [NCH-1:0] dcd_raw = {carrier_detect_b_b, carrier_detect_a_b};
	wire logic [NCH-1:0] syn_raw = {sync_pin_b_in, sync_pin_a_in};

	scpc_ctrl_t          ctrl_ff    [NCH];
	logic [SCPC_DW-1:0]  txd_ff     [NCH];
	logic [SCPC_DW-1:0]  rxd_ff     [NCH];
	logic [SCPC_DW-1:0]  schr_ff    [NCH];
	logic [SCPC_DW-1:0]  rx_word    [NCH];
	logic [SCPC_DW-1:0]  ch_rd      [NCH];
	logic [4:0]          meta_ff    [NCH];
	logic [4:0]          stab_ff    [NCH];
	logic [NCH-1:0]      rx_full_ff, sync_hit_ff, req_tgl_ff, rx_seen_ff;
	logic [NCH-1:0]      wr_ff, rts_ff, dtr_ff, syo_ff, syoe_ff;
	logic [NCH-1:0]      ser_q, rx_tgl, ack_tgl, tx_busy;
	logic [SCPC_DW-1:0]  rdata_ff;

	// address decode shared by both channels
	wire logic       hi_ok  = (reg_addr[SCPC_AW-1:SCPC_CH_BIT+1] == SCPC_HI_ZERO);
	wire logic       ch_idx = reg_addr[SCPC_CH_BIT];
	wire logic [3:0] off    = reg_addr[3:0];
	wire logic [SCPC_DW-1:0] rd_word = hi_ok ? ch_rd[ch_idx] : SCPC_RD_NONE;

	// read data stands for one cycle after the read strobe
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= reg_rd ? rd_word : SCPC_RD_NONE;
		end
	end

	// outputs straight from flops
	assign reg_rdata                 = rdata_ff;
	assign serial_out_a              = ser_q[0];
	assign serial_out_b              = ser_q[1];
	assign wait_ready_out_a          = wr_ff[0];
	assign wait_ready_out_b          = wr_ff[1];
	assign sync_pin_a_out            = syo_ff[0];
	assign sync_pin_a_oe             = syoe_ff[0];
	assign sync_pin_b_out            = syo_ff[1];
	assign sync_pin_b_oe             = syoe_ff[1];
	assign send_request_or_clear_a_b = rts_ff[0];
	assign send_request_or_clear_b_b = rts_ff[1];
	assign terminal_ready_a_b        = dtr_ff[0];
	assign terminal_ready_b_b        = dtr_ff[1];

	for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
		// channel strobes
		wire logic acc     = hi_ok && (ch_idx == 1'(ch));
		wire logic wr_ctrl = reg_wr && acc && (off == SCPC_OFF_CTRL);
		wire logic wr_txd  = reg_wr && acc && (off == SCPC_OFF_TXD);
		wire logic wr_sync = reg_wr && acc && (off == SCPC_OFF_SYNC);
		wire logic rd_rxd  = reg_rd && acc && (off == SCPC_OFF_RXD);
		wire logic rd_stat = reg_rd && acc && (off == SCPC_OFF_STAT);

		// synchronised pins and link toggles
		wire logic ack_s  = stab_ff[ch][0];
		wire logic rx_s   = stab_ff[ch][1];
		wire logic cts_s  = stab_ff[ch][2];
		wire logic dcd_s  = stab_ff[ch][3];
		wire logic syn_s  = stab_ff[ch][4];
		wire logic new_rx = (rx_s != rx_seen_ff[ch]);
		wire logic hit    = new_rx && !ctrl_ff[ch].sync_ext && (rx_word[ch] == schr_ff[ch]);
		assign tx_busy[ch] = (req_tgl_ff[ch] != ack_s);

		wire scpc_stat_t stat = '{sync_hit: sync_hit_ff[ch], sync_in: syn_s, dcd: ~dcd_s,
			cts: ~cts_s, tx_busy: tx_busy[ch], rx_full: rx_full_ff[ch]};

		// register read selection
		assign ch_rd[ch] = (off == SCPC_OFF_CTRL) ? {2'h0, ctrl_ff[ch]} :
			(off == SCPC_OFF_RXD)  ? rxd_ff[ch] :
			(off == SCPC_OFF_STAT) ? {2'h0, stat} :
			(off == SCPC_OFF_SYNC) ? schr_ff[ch] : SCPC_RD_NONE;

		// two-flop synchronisers from pins and bit-clock domains
		always_ff @(posedge sys_clk or negedge rst_b) begin
			if (!rst_b) begin
				meta_ff[ch] <= 5'h1c;
				stab_ff[ch] <= 5'h1c;
			end else begin
				meta_ff[ch] <= {syn_raw[ch], dcd_raw[ch], cts_raw[ch], rx_tgl[ch], ack_tgl[ch]};
				stab_ff[ch] <= meta_ff[ch];
			end
		end

		// software registers; a write to transmit data is dropped while busy
		always_ff @(posedge sys_clk or negedge rst_b) begin
			if (!rst_b) begin
				ctrl_ff[ch]    <= SCPC_CTRL_RST;
				txd_ff[ch]     <= '0;
				schr_ff[ch]    <= '0;
				req_tgl_ff[ch] <= '0;
			end else begin
				if (wr_ctrl) ctrl_ff[ch] <= reg_wdata[5:0];
				if (wr_sync) schr_ff[ch] <= reg_wdata;
				if (wr_txd && !tx_busy[ch]) begin
					txd_ff[ch]     <= reg_wdata;
					req_tgl_ff[ch] <= ~req_tgl_ff[ch];
				end
			end
		end

		// received byte capture; a new byte wins over a clearing read
		always_ff @(posedge sys_clk or negedge rst_b) begin
			if (!rst_b) begin
				rx_seen_ff[ch]  <= '0;
				rxd_ff[ch]      <= '0;
				rx_full_ff[ch]  <= '0;
				sync_hit_ff[ch] <= '0;
			end else begin
				rx_seen_ff[ch]  <= rx_s;
				if (new_rx) rxd_ff[ch] <= rx_word[ch];
				rx_full_ff[ch]  <= new_rx || (rx_full_ff[ch] && !rd_rxd);
				sync_hit_ff[ch] <= hit || (sync_hit_ff[ch] && !rd_stat);
			end
		end

		// pin drivers: wait/ready, sync direction, send request, terminal ready
		always_ff @(posedge sys_clk or negedge rst_b) begin
			if (!rst_b) begin
				wr_ff[ch]   <= '0;
				syo_ff[ch]  <= '1;
				syoe_ff[ch] <= '0;
				rts_ff[ch]  <= '1;
				dtr_ff[ch]  <= '1;
			end else begin
				wr_ff[ch]   <= ctrl_ff[ch].wr_ready ? !(ctrl_ff[ch].wr_en && !tx_busy[ch])
					: (ctrl_ff[ch].wr_en && tx_busy[ch]);
				syoe_ff[ch] <= !ctrl_ff[ch].sync_ext;
				syo_ff[ch]  <= !sync_hit_ff[ch];
				rts_ff[ch]  <= !tx_busy[ch];
				dtr_ff[ch]  <= !ctrl_ff[ch].dtr_on;
			end
		end

		scpc_rx #(.DW(SCPC_DW)) u_rx (
			.rx_clk      (rxc[ch]),
			.rst_b       (rst_b),
			.serial_in   (sin[ch]),
			.carrier_b   (dcd_raw[ch]),
			.mult_raw    (ctrl_ff[ch].mult),
			.rx_word_ff  (rx_word[ch]),
			.done_tgl_ff (rx_tgl[ch])
		);

		scpc_tx #(.DW(SCPC_DW)) u_tx (
			.tx_clk        (txc[ch]),
			.rst_b         (rst_b),
			.req_tgl       (req_tgl_ff[ch]),
			.clear_b       (cts_raw[ch]),
			.mult_raw      (ctrl_ff[ch].mult),
			.tx_word       (txd_ff[ch]),
			.serial_out_ff (ser_q[ch]),
			.ack_tgl_ff    (ack_tgl[ch])
		);

		wait_active_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
			(ctrl_ff[ch].wr_en && !ctrl_ff[ch].wr_ready && tx_busy[ch]) |=> wr_ff[ch])
			else $error("wait not raised while busy");
		ready_active_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
			(ctrl_ff[ch].wr_en && ctrl_ff[ch].wr_ready && !tx_busy[ch]) |=> !wr_ff[ch])
			else $error("ready not low while free");
		sync_in_dir_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
			ctrl_ff[ch].sync_ext |=> !syoe_ff[ch])
			else $error("sync pin driven in external mode");
		sync_out_dir_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
			(!ctrl_ff[ch].sync_ext && sync_hit_ff[ch]) |=> (syoe_ff[ch] && !syo_ff[ch]))
			else $error("sync hit not reported");
		rts_send_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
			(wr_txd && !tx_busy[ch]) |=> ##1 !rts_ff[ch])
			else $error("send request not low while sending");
		dtr_level_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
			wr_ctrl |=> ##1 (dtr_ff[ch] == !$past(reg_wdata[4], 2)))
			else $error("terminal ready does not follow control");
	end
endmodule

/* scpc_tx.sv */
// transmitter of one channel, clocked by that channel's transmit bit clock
// assumes the word is held steady by the register side while a request is pending
`timescale 1ns/1ps
module scpc_tx #(
	parameter int DW = scpc_pkg::SCPC_DW
) (
	input  wire logic          tx_clk,
	input  wire logic          rst_b,
	input  wire logic          req_tgl,
	input  wire logic          clear_b,
	input  wire logic [1:0]    mult_raw,
	input  wire logic [DW-1:0] tx_word,
	output logic               serial_out_ff,
	output logic               ack_tgl_ff
);
	import scpc_pkg::*;

	logic [3:0]    meta_ff, sync_ff;
	logic          seen_ff, active_ff;
	logic [5:0]    cnt_ff;
	logic [3:0]    left_ff;
	logic [DW:0]   shift_ff;

	wire logic       req_s    = sync_ff[0];
	wire logic       cts_ok   = ~sync_ff[1];
	wire logic [5:0] div_m1   = scpc_div_m1(sync_ff[3:2]);
	wire logic       cnt_zero = (cnt_ff == SCPC_DIV_X1);
	wire logic       load     = !active_ff && (req_s != seen_ff) && cts_ok;
	wire logic       step     = active_ff && cnt_zero;

	// two-flop synchronisers for request, clear-to-send and config
	always_ff @(posedge tx_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= '1;
			sync_ff <= '1;
		end else begin
			meta_ff <= {mult_raw, clear_b, req_tgl};
			sync_ff <= meta_ff;
		end
	end

	// shifter: start bit, data lsb first, stop bit
	always_ff @(posedge tx_clk or negedge rst_b) begin
		if (!rst_b) begin
			seen_ff       <= '0;
			active_ff     <= '0;
			cnt_ff        <= '0;
			left_ff       <= '0;
			shift_ff      <= '1;
			serial_out_ff <= '1;
			ack_tgl_ff    <= '0;
		end else if (load) begin
			seen_ff       <= req_s;
			active_ff     <= '1;
			cnt_ff        <= div_m1;
			left_ff       <= SCPC_TX_LEFT;
			shift_ff      <= {1'h1, tx_word};
			serial_out_ff <= '0;
		end else if (step && left_ff != 4'h0) begin
			cnt_ff        <= div_m1;
			left_ff       <= left_ff - 4'h1;
			serial_out_ff <= shift_ff[0];
			shift_ff      <= {1'h1, shift_ff[DW:1]};
		end else if (step) begin
			active_ff  <= '0;
			ack_tgl_ff <= ~ack_tgl_ff;
		end else if (active_ff) begin
			cnt_ff <= cnt_ff - 6'h01;
		end
	end

	tx_start_bit_a: assert property (@(posedge tx_clk) disable iff (!rst_b)
		load |=> (!serial_out_ff && active_ff))
		else $error("start bit not driven low");
	tx_bit_time_a: assert property (@(posedge tx_clk) disable iff (!rst_b)
		(step && left_ff != 4'h0) |=> (cnt_ff == $past(div_m1)))
		else $error("transmit bit period wrong");
	tx_idle_mark_a: assert property (@(posedge tx_clk) disable iff (!rst_b)
		(!active_ff && !load) |=> serial_out_ff)
		else $error("line not idle high");
endmodule

/* testbench.sv */
// self-checking bench for the two-channel serial pin controller
// assumes a modem model on each channel's far side
`timescale 1ns/1ps
module testbench;
	import scpc_pkg::*;
	logic       sys_clk = 1'b0, rst_b = 1'b0, bclk = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic       sync_drv_a = 1'b0, sync_drv_b = 1'b1, sync_pin_a_in, sync_pin_b_in;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic       serial_in_a, serial_in_b, serial_out_a, serial_out_b;
	logic       wait_ready_out_a, wait_ready_out_b, sync_pin_a_out, sync_pin_a_oe;
	logic       sync_pin_b_out, sync_pin_b_oe, terminal_ready_a_b, terminal_ready_b_b;
	logic       send_request_or_clear_a_b, send_request_or_clear_b_b;
	logic       clear_to_send_a_b, clear_to_send_b_b, carrier_detect_a_b, carrier_detect_b_b;
	int         err_count = 0, tests_run = 0;
	wire  [1:0] rts  = {send_request_or_clear_b_b, send_request_or_clear_a_b};
	wire  [1:0] dtr  = {terminal_ready_b_b, terminal_ready_a_b};
	wire  [1:0] wrdy = {wait_ready_out_b, wait_ready_out_a};
	// register clock, and a free bit clock of another phase
	always #25 sys_clk = ~sys_clk;
	initial #7 forever #62.5 bclk = ~bclk;
	// sync pins: the unit drives when enabled, the bench otherwise
	assign sync_pin_a_in = sync_pin_a_oe ? sync_pin_a_out : sync_drv_a;
	assign sync_pin_b_in = sync_pin_b_oe ? sync_pin_b_out : sync_drv_b;
	// the unit and its two modems
	scpc_top DUT (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.rx_bit_clock_a(bclk), .rx_bit_clock_b(bclk), .tx_bit_clock_a(bclk),
		.tx_bit_clock_b(bclk), .serial_in_a, .serial_in_b, .serial_out_a, .serial_out_b,
		.wait_ready_out_a, .wait_ready_out_b, .sync_pin_a_in, .sync_pin_a_out, .sync_pin_a_oe,
		.sync_pin_b_in, .sync_pin_b_out, .sync_pin_b_oe, .send_request_or_clear_a_b,
		.send_request_or_clear_b_b, .clear_to_send_a_b, .clear_to_send_b_b,
		.carrier_detect_a_b, .carrier_detect_b_b, .terminal_ready_a_b, .terminal_ready_b_b);
	scpc_modem modem_a (.bclk, .txd(serial_out_a), .rxd(serial_in_a),
		.cts_b(clear_to_send_a_b), .dcd_b(carrier_detect_a_b));
	scpc_modem modem_b (.bclk, .txd(serial_out_b), .rxd(serial_in_b),
		.cts_b(clear_to_send_b_b), .dcd_b(carrier_detect_b_b));
	// bit clocks per bit for a multiplier code
	function automatic int fac(input logic [1:0] m);
		fac = m == 2'd0 ? 1 : 8 << m;
	endfunction
	// compare one value and count it
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// counts and verdict, then stop
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// one-cycle register write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// one-cycle register read, data taken in the following cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	// bounded wait for a status bit
	task automatic poll(input logic [7:0] a, input int i, input logic v);
		logic [7:0] s;
		for (int n = 0; n < 3000; n++) begin
			rd(a, s);
			if (s[i] === v)
				return;
		end
		err_count++;
		tally_and_finish();
	endtask
	// control and sync registers, write-only and unmapped places, terminal ready
	task automatic t_regs();
		logic [7:0] s;
		wr(8'h00, 8'h1b);
		wr(8'h14, 8'ha5);
		wr(8'h07, 8'hff);
		rd(8'h00, s);
		check(s, 8'h1b);
		rd(8'h14, s);
		check(s, 8'ha5);
		rd(8'h01, s);
		check(s, 8'h00);
		rd(8'h27, s);
		check(s, 8'h00);
		check({dtr, wrdy}, 4'h9);
		check({sync_pin_b_oe, sync_pin_b_out}, 2'b11);
		wr(8'h00, 8'h00);
		repeat (3) @(negedge sys_clk);
		check(dtr, 2'b11);
		$display("regs done");
	endtask
	// one byte out, optionally held back by clear-to-send first
	task automatic t_tx(input int ch, input logic [1:0] m, input logic [7:0] d, input bit hold);
		logic [7:0] b, got;
		logic       ok;
		scpc_ctrl_t c;
		b = ch ? 8'h10 : 8'h00;
		c = '{sync_ext: 1'b0, dtr_on: 1'b0, wr_ready: m[0], wr_en: 1'b1, mult: m};
		wr(b, {2'b00, c});
		modem_a.cts_b <= hold;
		repeat (4) @(posedge bclk);
		wr(b + 8'h01, d);
		if (hold) begin
			repeat (40) @(negedge bclk) check(serial_out_a, 1'b1);
			@(posedge sys_clk);
			modem_a.cts_b <= 1'b0;
		end
		fork
			if (ch == 1)
				modem_b.get(fac(m), got, ok);
			else
				modem_a.get(fac(m), got, ok);
			begin
				repeat (6) @(negedge sys_clk);
				check({rts[ch], wrdy[ch]}, 2'b01);
			end
		join
		check({ok, got}, {1'b1, d});
		poll(b + 8'h03, 1, 1'b0);
		@(negedge sys_clk);
		check({rts[ch], wrdy[ch]}, 2'b10);
		$display("tx done");
	endtask
	// one byte in, or none while the carrier is absent
	task automatic t_rx(input int ch, input logic [1:0] m, input logic [7:0] d, input bit cd);
		logic [7:0] b, s;
		b = ch ? 8'h10 : 8'h00;
		wr(b, {6'h00, m});
		modem_a.dcd_b <= cd;
		repeat (4) @(posedge bclk);
		if (ch == 1)
			modem_b.send(d, fac(m));
		else
			modem_a.send(d, fac(m));
		if (cd) begin
			repeat (10) @(posedge sys_clk);
			rd(b + 8'h03, s);
			check({s[3], s[0]}, 2'b00);
			@(posedge sys_clk);
			modem_a.dcd_b <= 1'b0;
		end else begin
			poll(b + 8'h03, 0, 1'b1);
			rd(b + 8'h02, s);
			check(s, d);
		end
		$display("rx done");
	endtask
	// sync pin as input, then as output reporting a matched character
	task automatic t_sync();
		logic [7:0] s;
		int         n;
		wr(8'h00, 8'h20);
		sync_drv_a <= 1'b0;
		repeat (4) @(negedge sys_clk);
		check(sync_pin_a_oe, 1'b0);
		rd(8'h03, s);
		check(s[4], 1'b0);
		wr(8'h04, 8'h96);
		wr(8'h00, 8'h01);
		sync_drv_a <= 1'b1;
		repeat (4) @(posedge bclk);
		check({sync_pin_a_oe, sync_pin_a_out}, 2'b11);
		modem_a.send(8'h96, 16);
		for (n = 0; n < 200 && sync_pin_a_out !== 1'b0; n++)
			@(negedge sys_clk);
		check(sync_pin_a_out, 1'b0);
		rd(8'h03, s);
		check(s[5], 1'b1);
		rd(8'h02, s);
		check(s, 8'h96);
		check(sync_pin_a_out, 1'b1);
		$display("sync done");
	endtask
	// reset, then each scenario in turn
	initial begin
		@(negedge sys_clk);
		check({rts, dtr, wrdy}, 6'h3c);
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_regs();
		for (int m = 0; m < 4; m++)
			t_tx(0, m[1:0], 8'ha5 ^ (8'h11 << m), m == 0);
		t_tx(1, 2'd1, 8'h3e, 1'b0);
		for (int m = 0; m < 4; m++)
			t_rx(0, m[1:0], 8'h69 ^ (8'h11 << m), 1'b0);
		t_rx(1, 2'd2, 8'hc1, 1'b0);
		t_rx(0, 2'd0, 8'h55, 1'b1);
		t_sync();
		tally_and_finish();
	end
endmodule
